// File: motor_bank_params.svh
// Offsets, field positions, reset values and timing counts of the motor register bank
`ifndef MOTOR_BANK_PARAMS_SVH
`define MOTOR_BANK_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets on the two-wire bus
// ----------------------------------------------------------------------------
`define REG_PERIOD_HI 8'h13
`define REG_PERIOD_LO 8'h14
`define REG_VCONST_HI 8'h15
`define REG_VCONST_LO 8'h16
`define REG_ROTOR_POS 8'h19
`define REG_SUPPLY 8'h1a
`define REG_SPEED_REQ 8'h1b
`define REG_SPEED_BUF 8'h1c
`define REG_FAULT 8'h1e
`define REG_PARAM_A 8'h20
`define REG_PARAM_B 8'h21
`define REG_PARAM_C 8'h22

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PA_FREQ_BIT 7
`define PB_ADJ_BIT 7
`define PC_ADVMD_BIT 7
`define FIELD_MSB 6
`define SPD_BUF_MSB 8
`define SPD_BUF_LSB 1

// ----------------------------------------------------------------------------
// Reset values and bus address
// ----------------------------------------------------------------------------
`define PARAM_A_RESET 8'h00
`define PARAM_B_RESET 8'h00
`define PARAM_C_RESET 8'h00
`define UNMAPPED_READ 8'h00
`define DEV_ADDR_DEFAULT 7'h52

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 20
`define SW_PERIOD_SLOW_NS 40000
`define SW_PERIOD_FAST_NS 20000
`define SW_SLOW_CYCLES (`SW_PERIOD_SLOW_NS / `CLK_PERIOD_NS)
`define SW_FAST_CYCLES (`SW_PERIOD_FAST_NS / `CLK_PERIOD_NS)
`define ADV_UNIT_NS 2500
`define ADV_UNIT_CYCLES ((`ADV_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: motor_bank_pkg.sv
// Types shared by the motor register bank and its field decoder
package motor_bank_pkg;

  // --------------------------------------------------------------------------
  // Serial bus slave states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_REG = 3'b010,
    I2C_WDATA = 3'b011,
    I2C_RDATA = 3'b100
  } i2c_state_t;

  // Decoded significand-shift value, optionally scaled
  typedef logic [17:0] dec_value_t;

  // --------------------------------------------------------------------------
  // State of the bank
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] scl_sync; // Clock pin synchroniser
    logic [1:0] sda_sync; // Data pin synchroniser
    logic scl_prev; // Settled clock, one cycle old
    logic sda_prev; // Settled data, one cycle old
    i2c_state_t state; // Bus slave state
    logic [3:0] bit_cnt; // Clock rises within a byte
    logic [7:0] shift; // Byte in flight
    logic read_mode; // Direction bit of the address byte
    logic [7:0] ptr; // Register pointer
    logic sda_drive; // Pull data low
    logic [7:0] param_a; // Frequency and resistance
    logic [7:0] param_b; // Adjust mode and constant
    logic [7:0] param_c; // Advance mode and delay
    logic [7:0] period_lo_hold; // Low byte caught with high byte
    logic [7:0] vconst_lo_hold; // Low byte caught with high byte
    logic [10:0] sw_cnt; // Switching period divider
    logic sw_tick; // Switching period strobe
  } bank_state_t;

  // State of one field decoder
  typedef struct packed {
    dec_value_t value;
  } decode_state_t;

endpackage : motor_bank_pkg

// File: shift_field_decoder.sv
// Decoder of a 7-bit significand/shift field into a scaled integer
`timescale 1ns/100ps
`include "motor_bank_params.svh"

module shift_field_decoder #(
  parameter int unsigned SCALE = 1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [6:0] code,
  output motor_bank_pkg::dec_value_t value
);
  import motor_bank_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  decode_state_t q; // Registered result
  decode_state_t n; // Next result
  logic [31:0] product; // Wide product before trimming

  // Significand in bits 3:0 moved up by bits 6:4, then scaled
  always_comb begin
    n = q;
    product = ({28'h0, code[3:0]} << code[`FIELD_MSB:4]) * SCALE;
    n.value = product[17:0];
  end

  // Result register; one cycle behind the field
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign value = q.value;

endmodule : shift_field_decoder

// File: motor_param_readback_bank.sv
// Motor monitor and parameter register bank behind a two-wire serial slave
`timescale 1ns/100ps
`include "motor_bank_params.svh"

module motor_param_readback_bank #(
  parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [15:0] elec_period_value,
  input wire logic [15:0] velocity_const_value,
  input wire logic [7:0] sensed_rotor_position,
  input wire logic [7:0] supply_level_code,
  input wire logic [7:0] speed_request_code,
  input wire logic [8:0] buffered_speed_request_code,
  input wire logic stuck_closed_loop_flag,
  input wire logic stuck_open_loop_flag,
  input wire logic no_motor_flag,
  input wire logic abnormal_const_flag,
  input wire logic abnormal_speed_flag,
  input wire logic current_limit_lock_flag,
  output logic switch_freq_select,
  output logic switch_period_tick,
  output logic [6:0] phase_resistance_field,
  output logic loop_adjust_mode,
  output logic [6:0] bemf_const_field,
  output logic advance_mode_select,
  output logic [6:0] advance_delay_code,
  output motor_bank_pkg::dec_value_t phase_resistance_dig,
  output motor_bank_pkg::dec_value_t bemf_const_dig,
  output motor_bank_pkg::dec_value_t advance_time_value
);
  import motor_bank_pkg::*;

  // --------------------------------------------------------------------------
  // Constants
  // --------------------------------------------------------------------------
  localparam logic [10:0] SW_SLOW_LAST = 11'(`SW_SLOW_CYCLES - 1); // 25 kHz
  localparam logic [10:0] SW_FAST_LAST = 11'(`SW_FAST_CYCLES - 1); // 50 kHz
  localparam int unsigned ADV_CYC = `ADV_UNIT_CYCLES; // Cycles per 2.5 us
  localparam int unsigned DEC_SCALE [3] = '{1, 1, ADV_CYC}; // Per decoder

  // --------------------------------------------------------------------------
  // State and decoded bus events
  // --------------------------------------------------------------------------
  bank_state_t q; // Registered state
  bank_state_t n; // Next state
  logic scl_now; // Settled clock level
  logic sda_now; // Settled data level
  logic scl_rise; // Bus clock rising
  logic scl_fall; // Bus clock falling
  logic start_cond; // Data falls, clock high
  logic stop_cond; // Data rises, clock high
  logic ld_fire; // Read byte is loaded this cycle
  logic wr_fire; // Written byte lands this cycle
  logic [7:0] rd_byte; // Byte the pointer selects
  logic [5:0] fault_vec; // Live fault inputs
  logic [10:0] sw_last; // Divider terminal count
  logic [2:0][6:0] dec_code; // Fields into decoders
  dec_value_t dec_out [3]; // Decoded fields

  // Only the second synchroniser stage is looked at
  assign scl_now = q.scl_sync[1];
  assign sda_now = q.sda_sync[1];
  assign scl_rise = scl_now & ~q.scl_prev;
  assign scl_fall = ~scl_now & q.scl_prev;
  assign start_cond = scl_now & q.scl_prev & q.sda_prev & ~sda_now;
  assign stop_cond = scl_now & q.scl_prev & ~q.sda_prev & sda_now;
  assign ld_fire = scl_fall && (q.bit_cnt == 4'd9) &&
                   ((q.state == I2C_ADDR && q.read_mode) || q.state == I2C_RDATA);
  assign wr_fire = scl_fall && (q.bit_cnt == 4'd8) && (q.state == I2C_WDATA);
  assign fault_vec = {stuck_closed_loop_flag, stuck_open_loop_flag, no_motor_flag,
                      abnormal_const_flag, abnormal_speed_flag, current_limit_lock_flag};
  assign sw_last = q.param_a[`PA_FREQ_BIT] ? SW_FAST_LAST : SW_SLOW_LAST;

  // --------------------------------------------------------------------------
  // Read multiplexer
  // --------------------------------------------------------------------------
  // Live values are sampled when the byte is loaded, not as it shifts out
  always_comb begin
    case (q.ptr)
      `REG_PERIOD_HI: rd_byte = elec_period_value[15:8];
      `REG_PERIOD_LO: rd_byte = q.period_lo_hold;
      `REG_VCONST_HI: rd_byte = velocity_const_value[15:8];
      `REG_VCONST_LO: rd_byte = q.vconst_lo_hold;
      `REG_ROTOR_POS: rd_byte = sensed_rotor_position;
      `REG_SUPPLY: rd_byte = supply_level_code;
      `REG_SPEED_REQ: rd_byte = speed_request_code;
      `REG_SPEED_BUF: rd_byte = buffered_speed_request_code[`SPD_BUF_MSB:`SPD_BUF_LSB];
      `REG_FAULT: rd_byte = {2'b00, fault_vec};
      `REG_PARAM_A: rd_byte = q.param_a;
      `REG_PARAM_B: rd_byte = q.param_b;
      `REG_PARAM_C: rd_byte = q.param_c;
      default: rd_byte = `UNMAPPED_READ; // Unmapped reads as zero
    endcase
  end

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    n = q;
    // Pins pass two flip-flops before any decode
    n.scl_sync = {q.scl_sync[0], scl_in};
    n.sda_sync = {q.sda_sync[0], sda_in};
    n.scl_prev = scl_now;
    n.sda_prev = sda_now;

    // Switching period divider, terminal count set by frequency select
    if (q.sw_cnt >= sw_last) begin
      n.sw_cnt = 11'h000;
      n.sw_tick = 1'b1;
    end else begin
      n.sw_cnt = q.sw_cnt + 11'h001;
      n.sw_tick = 1'b0;
    end

    if (start_cond) begin
      // Start or repeated start: address byte follows
      n.state = I2C_ADDR;
      n.bit_cnt = 4'h0;
      n.sda_drive = 1'b0;
    end else if (stop_cond) begin
      // Stop: release the line
      n.state = I2C_IDLE;
      n.bit_cnt = 4'h0;
      n.sda_drive = 1'b0;
    end else begin
      // Count rises; receiving states shift the data bit in
      if (scl_rise && q.state != I2C_IDLE) begin
        n.bit_cnt = q.bit_cnt + 4'h1;
        if (q.state != I2C_RDATA && q.bit_cnt < 4'd8) begin
          n.shift = {q.shift[6:0], sda_now};
        end
        // Master not acknowledging ends the read burst
        if (q.state == I2C_RDATA && q.bit_cnt == 4'd8 && sda_now) begin
          n.state = I2C_IDLE;
        end
      end
      if (scl_fall) begin
        unique case (q.state)
          I2C_IDLE: begin
            n.sda_drive = 1'b0;
          end
          I2C_ADDR: begin
            if (q.bit_cnt == 4'd8) begin
              // Acknowledge only our own address
              if (q.shift[7:1] == DEV_ADDR) begin
                n.sda_drive = 1'b1;
                n.read_mode = q.shift[0];
              end else begin
                n.state = I2C_IDLE;
              end
            end else if (q.bit_cnt == 4'd9 && !q.read_mode) begin
              n.sda_drive = 1'b0;
              n.bit_cnt = 4'h0;
              n.state = I2C_REG;
            end
          end
          I2C_REG: begin
            if (q.bit_cnt == 4'd8) begin
              n.ptr = q.shift;
              n.sda_drive = 1'b1;
            end else if (q.bit_cnt == 4'd9) begin
              n.sda_drive = 1'b0;
              n.bit_cnt = 4'h0;
              n.state = I2C_WDATA;
            end
          end
          I2C_WDATA: begin
            if (q.bit_cnt == 4'd8) begin
              // Every byte is acknowledged; read-only offsets ignore it
              n.sda_drive = 1'b1;
              n.ptr = q.ptr + 8'h01;
              case (q.ptr)
                `REG_PARAM_A: n.param_a = q.shift;
                `REG_PARAM_B: n.param_b = q.shift;
                `REG_PARAM_C: n.param_c = q.shift;
                default: n.ptr = q.ptr + 8'h01;
              endcase
            end else if (q.bit_cnt == 4'd9) begin
              n.sda_drive = 1'b0;
              n.bit_cnt = 4'h0;
            end
          end
          I2C_RDATA: begin
            if (q.bit_cnt >= 4'd1 && q.bit_cnt <= 4'd7) begin
              // Next bit, most significant first
              n.shift = {q.shift[6:0], 1'b0};
              n.sda_drive = ~q.shift[6];
            end else if (q.bit_cnt == 4'd8) begin
              // Release for the master's acknowledge
              n.sda_drive = 1'b0;
            end
          end
          default: begin
            n.state = I2C_IDLE;
            n.sda_drive = 1'b0;
          end
        endcase
        // Load of a read byte, after address or after master acknowledge
        if (ld_fire) begin
          n.state = I2C_RDATA;
          n.shift = rd_byte;
          n.sda_drive = ~rd_byte[7];
          n.bit_cnt = 4'h0;
          n.ptr = q.ptr + 8'h01;
          // Low bytes frozen so a later low read matches this high read
          if (q.ptr == `REG_PERIOD_HI) begin
            n.period_lo_hold = elec_period_value[7:0];
          end
          if (q.ptr == `REG_VCONST_HI) begin
            n.vconst_lo_hold = velocity_const_value[7:0];
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.param_a <= `PARAM_A_RESET;
      // Idle bus level, so no false edge shows once reset lets go
      q.scl_sync <= 2'b11;
      q.sda_sync <= 2'b11;
      q.scl_prev <= 1'b1;
      q.sda_prev <= 1'b1;
      q.param_b <= `PARAM_B_RESET;
      q.param_c <= `PARAM_C_RESET;
    end else begin
      q <= n;
    end
  end

  // --------------------------------------------------------------------------
  // Field decoders
  // --------------------------------------------------------------------------
  assign dec_code = {q.param_c[`FIELD_MSB:0], q.param_b[`FIELD_MSB:0], q.param_a[`FIELD_MSB:0]};

  for (genvar i = 0; i < 3; i++) begin : g_dec
    // Resistance, back-EMF constant, advance time in clock cycles
    shift_field_decoder #(
      .SCALE(DEC_SCALE[i])
    ) u_dec (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .code(dec_code[i]),
      .value(dec_out[i])
    );
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign sda_out = 1'b0; // Open drain: only ever pulls low
  assign sda_oe = q.sda_drive;
  assign switch_freq_select = q.param_a[`PA_FREQ_BIT];
  assign switch_period_tick = q.sw_tick;
  assign phase_resistance_field = q.param_a[`FIELD_MSB:0];
  assign loop_adjust_mode = q.param_b[`PB_ADJ_BIT];
  assign bemf_const_field = q.param_b[`FIELD_MSB:0];
  assign advance_mode_select = q.param_c[`PC_ADVMD_BIT];
  assign advance_delay_code = q.param_c[`FIELD_MSB:0];
  assign phase_resistance_dig = dec_out[0];
  assign bemf_const_dig = dec_out[1];
  assign advance_time_value = dec_out[2];

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  property p_period_lo_read;
    @(posedge sys_clk) disable iff (!rst_n)
    ld_fire && q.ptr == `REG_PERIOD_LO |=> q.shift == $past(q.period_lo_hold);
  endproperty
  a_period_lo_read: assert property (p_period_lo_read)
    else $error("period low byte not taken from hold");

  property p_vconst_hi_read;
    @(posedge sys_clk) disable iff (!rst_n)
    ld_fire && q.ptr == `REG_VCONST_HI |=> q.shift == $past(velocity_const_value[15:8]);
  endproperty
  a_vconst_hi_read: assert property (p_vconst_hi_read)
    else $error("velocity constant high byte wrong");

  property p_rotor_read;
    @(posedge sys_clk) disable iff (!rst_n)
    ld_fire && q.ptr == `REG_ROTOR_POS |=> q.shift == $past(sensed_rotor_position);
  endproperty
  a_rotor_read: assert property (p_rotor_read)
    else $error("rotor position read wrong");

  property p_supply_read;
    @(posedge sys_clk) disable iff (!rst_n)
    ld_fire && q.ptr == `REG_SUPPLY |=> q.shift == $past(supply_level_code);
  endproperty
  a_supply_read: assert property (p_supply_read)
    else $error("supply code read wrong");

  property p_speed_read;
    @(posedge sys_clk) disable iff (!rst_n)
    ld_fire && q.ptr == `REG_SPEED_REQ |=> q.shift == $past(speed_request_code);
  endproperty
  a_speed_read: assert property (p_speed_read)
    else $error("speed request read wrong");

  property p_speed_buf_read;
    @(posedge sys_clk) disable iff (!rst_n)
    ld_fire && q.ptr == `REG_SPEED_BUF |=> q.shift == $past(buffered_speed_request_code[8:1]);
  endproperty
  a_speed_buf_read: assert property (p_speed_buf_read)
    else $error("buffered speed read wrong");

  property p_fault_read;
    @(posedge sys_clk) disable iff (!rst_n)
    ld_fire && q.ptr == `REG_FAULT |=> q.shift == {2'b00, $past(fault_vec)};
  endproperty
  a_fault_read: assert property (p_fault_read)
    else $error("fault code read wrong");

  property p_sw_period;
    @(posedge sys_clk) disable iff (!rst_n)
    q.sw_tick |-> $past(q.sw_cnt) >= ($past(switch_freq_select) ? SW_FAST_LAST : SW_SLOW_LAST);
  endproperty
  a_sw_period: assert property (p_sw_period)
    else $error("switching strobe before period end");

  property p_res_decode;
    @(posedge sys_clk) disable iff (!rst_n)
    $stable(phase_resistance_field) |->
      phase_resistance_dig == 18'({14'h0, phase_resistance_field[3:0]} << phase_resistance_field[6:4]);
  endproperty
  a_res_decode: assert property (p_res_decode)
    else $error("resistance decode wrong");

  property p_adj_write;
    @(posedge sys_clk) disable iff (!rst_n)
    wr_fire && q.ptr == `REG_PARAM_B |=> loop_adjust_mode == $past(q.shift[7]);
  endproperty
  a_adj_write: assert property (p_adj_write)
    else $error("adjust mode not written");

  property p_bemf_decode;
    @(posedge sys_clk) disable iff (!rst_n)
    $stable(bemf_const_field) |->
      bemf_const_dig == 18'({14'h0, bemf_const_field[3:0]} << bemf_const_field[6:4]);
  endproperty
  a_bemf_decode: assert property (p_bemf_decode)
    else $error("back-EMF constant decode wrong");

  property p_advmd_write;
    @(posedge sys_clk) disable iff (!rst_n)
    wr_fire && q.ptr == `REG_PARAM_C |=> advance_mode_select == $past(q.shift[7]);
  endproperty
  a_advmd_write: assert property (p_advmd_write)
    else $error("advance mode not written");

  property p_adv_time;
    @(posedge sys_clk) disable iff (!rst_n)
    $stable(advance_delay_code) |-> advance_time_value ==
      18'(({14'h0, advance_delay_code[3:0]} << advance_delay_code[6:4]) * ADV_CYC);
  endproperty
  a_adv_time: assert property (p_adv_time)
    else $error("advance time decode wrong");

  property p_period_capture;
    @(posedge sys_clk) disable iff (!rst_n)
    ld_fire && q.ptr == `REG_PERIOD_HI |=>
      q.period_lo_hold == $past(elec_period_value[7:0]) && q.shift == $past(elec_period_value[15:8]);
  endproperty
  a_period_capture: assert property (p_period_capture)
    else $error("period pair not captured together");

endmodule : motor_param_readback_bank

// File: bus_host.sv
// Two-wire bus host model that drives the register bank's serial pins
`timescale 1ns/100ps
module bus_host (
  input wire logic sys_clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_low
);
  // Clocks per bus phase, well above the four the slave needs
  localparam int HALF = 10;
  // Idle bus: clock high, data released to its pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Wait on falling system edges, so no change lands on a sampling edge
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wt
  // Start or repeated start: data falls while the clock is high
  task automatic start();
    wt(2);
    sda_low = 1'b0;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    sda_low = 1'b1;
    wt(HALF);
    scl = 1'b0;
  endtask : start
  // Stop: data rises while the clock is high
  task automatic stop();
    wt(2);
    sda_low = 1'b1;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    sda_low = 1'b0;
    wt(HALF);
  endtask : stop
  // One bit; data moves two clocks after the clock fall, never with it
  task automatic bit_io(input logic b, output logic r);
    wt(2);
    sda_low = ~b;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    r = sda_wire;
    scl = 1'b0;
  endtask : bit_io
  // Eight bits MSB first then the ack slot; all ones in d releases data to read
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(last, ack);
  endtask : xfer
endmodule : bus_host

// File: tb.sv
// Self-checking bench of the motor monitor and parameter bank
`timescale 1ns/100ps
`include "motor_bank_params.svh"
module tb;
  import motor_bank_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl, sda_low, sda_out, sda_oe, tick, sel, adj, advm, a;
  logic [15:0] per = 16'h0, vc = 16'h0, v;
  logic [7:0] pos = 8'h0, sup = 8'h0, spd = 8'h0, r8;
  logic [8:0] sbuf = 9'h0;
  logic [5:0] flt = 6'h0;
  logic [6:0] rf, bf, df;
  dec_value_t rd, bd, at;
  int err_count = 0;
  int check_count = 0;
  // Open-drain data wire with a pull-up
  wire logic sda = ~(sda_low | (sda_oe & ~sda_out));
  always #10 sys_clk = ~sys_clk;
  bus_host host (.sys_clk(sys_clk), .sda_wire(sda), .scl(scl), .sda_low(sda_low));
  motor_param_readback_bank DUT (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .elec_period_value(per),
    .velocity_const_value(vc), .sensed_rotor_position(pos), .supply_level_code(sup),
    .speed_request_code(spd), .buffered_speed_request_code(sbuf),
    .stuck_closed_loop_flag(flt[5]), .stuck_open_loop_flag(flt[4]),
    .no_motor_flag(flt[3]), .abnormal_const_flag(flt[2]), .abnormal_speed_flag(flt[1]),
    .current_limit_lock_flag(flt[0]), .switch_freq_select(sel), .switch_period_tick(tick),
    .phase_resistance_field(rf), .loop_adjust_mode(adj), .bemf_const_field(bf),
    .advance_mode_select(advm), .advance_delay_code(df), .phase_resistance_dig(rd),
    .bemf_const_dig(bd), .advance_time_value(at));
  // Count a comparison, report a mismatch
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Significand shifted left by the count field
  function automatic logic [31:0] dec(input logic [6:0] f);
    return 32'(f[3:0]) << f[6:4];
  endfunction : dec
  // Write one byte; every byte must be acked
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    logic [7:0] r;
    logic a1, a2, a3;
    host.start();
    host.xfer({`DEV_ADDR_DEFAULT, 1'b0}, 1'b1, r, a1);
    host.xfer(ad, 1'b1, r, a2);
    host.xfer(d, 1'b1, r, a3);
    host.stop();
    chk({a1, a2, a3}, 0);
  endtask : wr
  // Read n bytes from ad on; host acks all but the last
  task automatic rdn(input logic [7:0] ad, input int n, output logic [15:0] q);
    logic [7:0] r;
    logic a1, a2, a3;
    q = 16'h0;
    host.start();
    host.xfer({`DEV_ADDR_DEFAULT, 1'b0}, 1'b1, r, a1);
    host.xfer(ad, 1'b1, r, a2);
    host.start();
    host.xfer({`DEV_ADDR_DEFAULT, 1'b1}, 1'b1, r, a3);
    chk({a1, a2, a3}, 0);
    for (int i = 1; i <= n; i++) begin
      host.xfer(8'hff, i == n, r, a1);
      q = {q[7:0], r};
    end
    host.stop();
  endtask : rdn
  // Cycles between two switching strobes, bounded
  task automatic gap(input int e);
    int n;
    n = 0;
    while (tick !== 1'b1 && n < 5000) begin
      @(negedge sys_clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (tick !== 1'b1 && n < 5000);
    chk(n, e);
  endtask : gap
  // Verdict and end of run
  task automatic stop_test();
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // Watchdog, about five times the expected run
  initial begin
    repeat (100000) @(posedge sys_clk);
    err_count++;
    stop_test();
  end
  // Main sequence
  initial begin
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    rdn(8'h20, 2, v);
    chk(v, 16'h0);
    wr(8'h20, 8'hb5);
    wr(8'h21, 8'hff);
    wr(8'h22, 8'h85);
    chk({sel, rf, adj, bf, advm, df}, 24'hb5ff85);
    chk(rd, dec(7'h35));
    chk(bd, dec(7'h7f));
    chk(at, dec(7'h05) * (2500 / 20));
    rdn(8'h21, 2, v);
    chk(v, 16'hff85);
    gap(20000 / 20);
    wr(8'h20, 8'h35);
    wr(8'h22, 8'h7f);
    chk({sel, advm, df}, 9'h07f);
    chk(at, dec(7'h7f) * (2500 / 20));
    gap(40000 / 20);
    per = 16'h01ff;
    vc = 16'h1234;
    pos = 8'h5a;
    sup = 8'h67;
    spd = 8'hff;
    sbuf = 9'h1a5;
    flt = 6'h2a;
    rdn(8'h13, 1, v);
    chk(v, 16'h01);
    per = 16'h0233;
    rdn(8'h14, 1, v);
    chk(v, 16'hff);
    rdn(8'h13, 2, v);
    chk(v, per);
    rdn(8'h15, 2, v);
    chk(v, vc);
    rdn(8'h19, 1, v);
    chk(v, pos);
    wr(8'h1a, 8'h00);
    rdn(8'h1a, 2, v);
    chk(v, {sup, spd});
    rdn(8'h1c, 1, v);
    chk(v, sbuf[8:1]);
    rdn(8'h1e, 1, v);
    chk(v, {2'b00, flt});
    flt = 6'h15;
    rdn(8'h1d, 2, v);
    chk(v, {10'h0, flt});
    host.start();
    host.xfer({`DEV_ADDR_DEFAULT ^ 7'h01, 1'b0}, 1'b1, r8, a);
    host.stop();
    chk(a, 1'b1);
    stop_test();
  end
endmodule : tb
